// ===== transmitter_event_flags.sv
// Notes on behaviour
// - Copy-done flag sets when enabled and unmasked
// - Copy flag drives interrupt low, summary high
// - Slip flag sets on slip when unmasked
// - Select bit picks slip or block start
// - Slip flag drives interrupt low, summary high
// - Status read-only: bit0 copy, bit1 slip
// - Mask bit0 gates copy flag, reset masked
// - Mask bit1 gates slip flag, reset masked
// - Mode bits1:0 pick copy trigger type
// - Mode bits3:2 pick slip trigger type
`timescale 1ns/1ps
`default_nettype none
module transmitter_event_flags
   import tx_event_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic BUF_COPY_DONE,
   input wire logic BUF_COPY_DISABLE,
   input wire logic ASYNC_SLIP,
   input wire logic BLOCK_START,
   input wire logic SLIP_OR_BLOCKSTART_SELECT,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic INT_N,
   output logic TX_SUMMARY
);
   logic [1:0] mask_reg;
   logic [1:0] mask_next;
   logic [3:0] mode_reg;
   logic [3:0] mode_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic int_n_reg;
   logic int_n_next;
   logic summary_reg;
   logic summary_next;
   logic [NUM_SRC-1:0] src;
   logic [NUM_SRC-1:0] hit;
   logic [NUM_SRC-1:0] flags;
   logic status_clear;
   logic [NUM_SRC-1:0] set_vec;

   // ****************************************************
   // Event sources
   // ****************************************************
   always_comb begin
      src[COPY_BIT] = BUF_COPY_DONE & ~BUF_COPY_DISABLE;
      src[SLIP_BIT] = SLIP_OR_BLOCKSTART_SELECT ?
         BLOCK_START : ASYNC_SLIP;
   end

   assign status_clear = REG_RD && (REG_ADDR == ADDR_STATUS);
   assign set_vec = hit & mask_reg;

   // ****************************************************
   // Per-source trigger and sticky flag
   // ****************************************************
   genvar i;
   generate
      for (i = 0; i < NUM_SRC; i = i + 1) begin : g_src
         edge_trigger u_trig (
            .clk(CLK),
            .arst_n(ARST_N),
            .src(src[i]),
            .mode(mode_reg[i*MODE_W +: MODE_W]),
            .hit(hit[i])
         );
         event_flag u_flag (
            .clk(CLK),
            .arst_n(ARST_N),
            .set(set_vec[i]),
            .clear(status_clear),
            .flag(flags[i])
         );

         chk_flag_sticky: assert property (
            @(posedge CLK) disable iff (!ARST_N)
            (flags[i] && !status_clear) |=> flags[i])
            else $error("pending flag lost");
      end
   endgenerate

   // ****************************************************
   // Register port
   // ****************************************************
   always_comb begin
      mask_next = mask_reg;
      mode_next = mode_reg;
      rdata_next = rdata_reg;
      if (REG_WR && REG_ADDR == ADDR_MASK) begin
         mask_next = REG_WDATA[1:0];
      end
      if (REG_WR && REG_ADDR == ADDR_MODE) begin
         mode_next = REG_WDATA[3:0];
      end
      if (REG_RD) begin
         case (REG_ADDR)
            ADDR_STATUS: rdata_next = {6'h00, flags};
            ADDR_MASK: rdata_next = {6'h00, mask_reg};
            ADDR_MODE: rdata_next = {4'h0, mode_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // ****************************************************
   // Interrupt pin and summary bit
   // ****************************************************
   always_comb begin
      int_n_next = ~(|flags);
      summary_next = |flags;
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mask_reg <= MASK_RESET;
         mode_reg <= MODE_RESET;
         rdata_reg <= RDATA_RESET;
         int_n_reg <= 1'b1;
         summary_reg <= 1'b0;
      end else begin
         mask_reg <= mask_next;
         mode_reg <= mode_next;
         rdata_reg <= rdata_next;
         int_n_reg <= int_n_next;
         summary_reg <= summary_next;
      end
   end

   assign REG_RDATA = rdata_reg;
   assign INT_N = int_n_reg;
   assign TX_SUMMARY = summary_reg;

   // ****************************************************
   // Checks
   // ****************************************************
   chk_copy_rise_set: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mask_reg[COPY_BIT] && mode_reg[1:0] == TRIG_RISE
       && $rose(src[COPY_BIT])) |=> flags[COPY_BIT])
      else $error("copy flag missed rising edge");

   chk_int_low_flags: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (flags != FLAG_RESET) |=> !INT_N)
      else $error("interrupt not driven low");

   chk_summary_flags: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (flags != FLAG_RESET) |=> TX_SUMMARY)
      else $error("summary bit not set");

   chk_slip_level_set: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mask_reg[SLIP_BIT] && mode_reg[3:2] == TRIG_LEVEL
       && !SLIP_OR_BLOCKSTART_SELECT && ASYNC_SLIP)
      |=> flags[SLIP_BIT])
      else $error("slip flag missed level");

   chk_blockstart_sel: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mask_reg[SLIP_BIT] && mode_reg[3:2] == TRIG_LEVEL
       && SLIP_OR_BLOCKSTART_SELECT && BLOCK_START)
      |=> flags[SLIP_BIT])
      else $error("slip flag missed block start");

   chk_status_read: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (REG_RD && REG_ADDR == ADDR_STATUS)
      |=> REG_RDATA == {6'h00, $past(flags)})
      else $error("status read value wrong");

   chk_copy_masked: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (!mask_reg[COPY_BIT] && !flags[COPY_BIT]) |=> !flags[COPY_BIT])
      else $error("masked copy flag set");

   chk_mask_read: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (REG_RD && REG_ADDR == ADDR_MASK)
      |=> REG_RDATA == {6'h00, $past(mask_reg)})
      else $error("mask read value wrong");

   chk_copy_fall_set: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mask_reg[COPY_BIT] && mode_reg[1:0] == TRIG_FALL
       && $fell(src[COPY_BIT])) |=> flags[COPY_BIT])
      else $error("copy flag missed falling edge");

   chk_slip_reserved: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mode_reg[3:2] == TRIG_RESV && !flags[SLIP_BIT])
      |=> !flags[SLIP_BIT])
      else $error("reserved mode set slip flag");

   chk_int_release: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (flags == FLAG_RESET) |=> INT_N)
      else $error("interrupt not released");

   chk_summary_release: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (flags == FLAG_RESET) |=> !TX_SUMMARY)
      else $error("summary bit not released");

   chk_pin_summary_pair: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      INT_N != TX_SUMMARY)
      else $error("pin and summary disagree");

   chk_read_clears: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (status_clear && set_vec == 2'b00) |=> flags == FLAG_RESET)
      else $error("status read left flag set");

   chk_copy_level_set: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mask_reg[COPY_BIT] && mode_reg[1:0] == TRIG_LEVEL
       && BUF_COPY_DONE && !BUF_COPY_DISABLE) |=> flags[COPY_BIT])
      else $error("copy flag missed level");

   chk_copy_disabled: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (BUF_COPY_DISABLE && mode_reg[1:0] != TRIG_FALL
       && !flags[COPY_BIT]) |=> !flags[COPY_BIT])
      else $error("disabled copy set flag");

   chk_copy_no_event: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mode_reg[1:0] == TRIG_RISE && !$rose(src[COPY_BIT])
       && !flags[COPY_BIT]) |=> !flags[COPY_BIT])
      else $error("copy flag set without rising edge");

   chk_slip_unselected: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (!SLIP_OR_BLOCKSTART_SELECT && !ASYNC_SLIP
       && mode_reg[3:2] == TRIG_LEVEL && !flags[SLIP_BIT])
      |=> !flags[SLIP_BIT])
      else $error("block start leaked into slip flag");

   chk_block_unselected: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (SLIP_OR_BLOCKSTART_SELECT && !BLOCK_START
       && mode_reg[3:2] == TRIG_LEVEL && !flags[SLIP_BIT])
      |=> !flags[SLIP_BIT])
      else $error("slip leaked into block start flag");

   chk_slip_rise_set: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mask_reg[SLIP_BIT] && mode_reg[3:2] == TRIG_RISE
       && $rose(src[SLIP_BIT])) |=> flags[SLIP_BIT])
      else $error("slip flag missed rising edge");

   chk_slip_fall_set: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mask_reg[SLIP_BIT] && mode_reg[3:2] == TRIG_FALL
       && $fell(src[SLIP_BIT])) |=> flags[SLIP_BIT])
      else $error("slip flag missed falling edge");

   chk_slip_no_event: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (mode_reg[3:2] == TRIG_FALL && !$fell(src[SLIP_BIT])
       && !flags[SLIP_BIT]) |=> !flags[SLIP_BIT])
      else $error("slip flag set without falling edge");

   chk_slip_masked: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (!mask_reg[SLIP_BIT] && !flags[SLIP_BIT]) |=> !flags[SLIP_BIT])
      else $error("masked slip flag set");

   chk_mode_read: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (REG_RD && REG_ADDR == ADDR_MODE)
      |=> REG_RDATA == {4'h0, $past(mode_reg)})
      else $error("mode read value wrong");

   chk_unmapped_read: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (REG_RD && REG_ADDR != ADDR_STATUS && REG_ADDR != ADDR_MASK
       && REG_ADDR != ADDR_MODE) |=> REG_RDATA == RDATA_RESET)
      else $error("unmapped read not zero");

   chk_rdata_hold: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      !REG_RD |=> $stable(REG_RDATA))
      else $error("read data changed without read");

   chk_mask_write: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (REG_WR && REG_ADDR == ADDR_MASK)
      |=> mask_reg == $past(REG_WDATA[1:0]))
      else $error("mask write not taken");

   chk_mode_write: assert property (
      @(posedge CLK) disable iff (!ARST_N)
      (REG_WR && REG_ADDR == ADDR_MODE)
      |=> mode_reg == $past(REG_WDATA[3:0]))
      else $error("mode write not taken");
endmodule
`default_nettype wire

// ===== tx_event_pkg.sv
`default_nettype none
package tx_event_pkg;
   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [7:0] ADDR_STATUS = 8'h0A;
   localparam logic [7:0] ADDR_MASK = 8'h0B;
   localparam logic [7:0] ADDR_MODE = 8'h0C;
   // ****************************************************
   // Field positions and widths
   // ****************************************************
   localparam int NUM_SRC = 2;
   localparam int COPY_BIT = 0;
   localparam int SLIP_BIT = 1;
   localparam int MODE_W = 2;
   localparam int COPY_MODE_POS = 0;
   localparam int SLIP_MODE_POS = 2;
   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [1:0] FLAG_RESET = 2'h0;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   // ****************************************************
   // Trigger encodings
   // ****************************************************
   localparam logic [1:0] TRIG_RISE = 2'h0;
   localparam logic [1:0] TRIG_FALL = 2'h1;
   localparam logic [1:0] TRIG_LEVEL = 2'h2;
   localparam logic [1:0] TRIG_RESV = 2'h3;
endpackage
`default_nettype wire

// ===== edge_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module edge_trigger
   import tx_event_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic src,
   input wire logic [1:0] mode,
   output logic hit
);
   logic prev_reg;
   logic prev_next;

   // ****************************************************
   // Previous level and trigger decode
   // ****************************************************
   always_comb begin
      prev_next = src;
      case (mode)
         TRIG_RISE: hit = src & ~prev_reg;
         TRIG_FALL: hit = ~src & prev_reg;
         TRIG_LEVEL: hit = src;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
      end
   end
endmodule
`default_nettype wire

// ===== event_flag.sv
`timescale 1ns/1ps
`default_nettype none
module event_flag (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic set,
   input wire logic clear,
   output logic flag
);
   logic flag_reg;
   logic flag_next;

   // ****************************************************
   // Sticky flag, set wins over clear
   // ****************************************************
   always_comb begin
      flag_next = flag_reg;
      if (clear) begin
         flag_next = 1'b0;
      end
      if (set) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag = flag_reg;
endmodule
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
   import tx_event_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] rdata,
   output logic [7:0] addr,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata
);
   initial begin
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
   end
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == ADDR_MODE && v[1:0] == TRIG_RESV) v[1:0] = TRIG_RISE;
      if (a == ADDR_MODE && v[3:2] == TRIG_RESV) v[3:2] = TRIG_RISE;
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~v;
   endtask
   // Status read identifies the source
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask
endmodule
`default_nettype wire

// ===== transmitter_event_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
module transmitter_event_flags_test
   import tx_event_pkg::*;
();
   logic clk, arst_n, cdone, cdis, slip, blk, sel, wr, rd, int_n, summ;
   logic [7:0] addr, wdata, rdata, got;
   logic [31:0] seed = 32'h26;
   logic [31:0] r;
   int fail_count = 0;
   int n_checks = 0;
   transmitter_event_flags dut(.CLK(clk), .ARST_N(arst_n),
      .BUF_COPY_DONE(cdone), .BUF_COPY_DISABLE(cdis), .ASYNC_SLIP(slip),
      .BLOCK_START(blk), .SLIP_OR_BLOCKSTART_SELECT(sel), .REG_ADDR(addr),
      .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .INT_N(int_n), .TX_SUMMARY(summ));
   host_model host(.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
      .rd(rd), .wdata(wdata));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Source 0 copy, 1 slip, 2 block, 3 unselected block, 4 copy off,
   // 5 unselected slip
   function automatic logic [7:0] exp_stat(int s, logic [1:0] m,
      logic [1:0] k, logic [2:0] lv);
      logic [4:0] q;
      logic hit;
      q = {1'b0, lv, 1'b0};
      hit = 1'b0;
      for (int i = 1; i < 5; i++) begin
         if (m == TRIG_RISE) hit |= q[i] & ~q[i-1];
         if (m == TRIG_FALL) hit |= ~q[i] & q[i-1];
         if (m == TRIG_LEVEL) hit |= q[i];
      end
      if (s >= 3) hit = 1'b0;
      if (s == 0) return {7'h00, hit & k[0]};
      return {6'h00, hit & k[1], 1'b0};
   endfunction
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic evt(int s, logic [1:0] m, logic [1:0] k, logic [2:0] lv);
      logic [7:0] e;
      logic [3:0] q;
      e = exp_stat(s, m, k, lv);
      q = {1'b0, lv};
      host.write(ADDR_MODE, {4'h0, m, m});
      host.write(ADDR_MASK, {6'h00, k});
      @(posedge clk);
      sel <= (s == 2 || s == 5);
      cdis <= (s == 4);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         cdone <= (s == 0 || s == 4) && q[i];
         slip <= (s == 1 || s == 5) && q[i];
         blk <= (s == 2 || s == 3) && q[i];
      end
      repeat (3) @(posedge clk);
      #1;
      chk("int_n", {7'h00, e == 8'h00}, {7'h00, int_n});
      chk("summary", {7'h00, e != 8'h00}, {7'h00, summ});
      host.read(ADDR_STATUS, got);
      chk("status", e, got);
      repeat (2) @(posedge clk);
      #1;
      chk("int_release", 8'h01, {7'h00, int_n});
      chk("summary_release", 8'h00, {7'h00, summ});
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ****
   // Clock, watchdog, sequence
   // ****
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #500us;
      fail_count++;
      wrap_up();
   end
   initial begin
      arst_n = 1'b0;
      {cdone, cdis, slip, blk, sel} = 5'h00;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      host.read(ADDR_MASK, got);
      chk("mask_reset", 8'h00, got);
      host.read(ADDR_MODE, got);
      chk("mode_reset", 8'h00, got);
      host.write(ADDR_STATUS, 8'hFF);
      host.read(ADDR_STATUS, got);
      chk("status_ro", 8'h00, got);
      host.write(ADDR_MASK, 8'hFF);
      host.read(ADDR_MASK, got);
      chk("mask_bits", 8'h03, got);
      host.write(ADDR_MODE, 8'hF6);
      host.read(ADDR_MODE, got);
      chk("mode_bits", 8'h06, got);
      host.read(8'h55, got);
      chk("unmapped", 8'h00, got);
      $display("test registers done");
      for (int s = 0; s < 6; s++) begin
         for (int m = 0; m < 3; m++) begin
            evt(s, 2'(m), 2'h3, 3'b010);
         end
      end
      $display("test modes done");
      repeat (30) begin
         r = rnd();
         evt(int'(r[31:16] % 6), (r[9:8] == 2'h3) ? 2'h2 : r[9:8],
            r[11:10], r[14:12]);
      end
      $display("test random done");
      host.write(ADDR_MASK, 8'h01);
      cdis <= 1'b0;
      host.write(ADDR_MODE, 8'h02);
      cdone <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("int_pending", 8'h00, {7'h00, int_n});
      @(posedge clk);
      cdone <= 1'b0;
      arst_n <= 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk("int_after_reset", 8'h01, {7'h00, int_n});
      host.read(ADDR_STATUS, got);
      chk("status_after_reset", 8'h00, got);
      host.read(ADDR_MASK, got);
      chk("mask_after_reset", 8'h00, got);
      host.read(ADDR_MODE, got);
      chk("mode_after_reset", 8'h00, got);
      $display("test reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
